// *** design/iex_pkg.sv ***
// shared constants and types of the i2c port expander control block
package iex_pkg;

    // fixed upper five bits of the seven-bit target address
    localparam logic [4:0] ADDR_FIXED   = 5'h1D;

    // command codes, three low bits of the command byte
    localparam logic [2:0] CMD_IN0      = 3'h0;
    localparam logic [2:0] CMD_IN1      = 3'h1;
    localparam logic [2:0] CMD_OUT0     = 3'h2;
    localparam logic [2:0] CMD_OUT1     = 3'h3;
    localparam logic [2:0] CMD_POL0     = 3'h4;
    localparam logic [2:0] CMD_POL1     = 3'h5;
    localparam logic [2:0] CMD_CFG0     = 3'h6;
    localparam logic [2:0] CMD_CFG1     = 3'h7;
    localparam logic [2:0] CMD_RST      = 3'h0;

    // register reset values, both ports together
    localparam logic [15:0] OUT_RST     = 16'hFFFF;
    localparam logic [15:0] POL_RST     = 16'h0000;
    localparam logic [15:0] CFG_RST     = 16'hFFFF;

    // bit count of one byte on the bus
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam int         PORT_W       = 8;

    // timing, figures in their own unit and derived cycle counts
    localparam int CLK_HZ               = 40_000_000;
    localparam int SPIKE_NS             = 50;
    localparam int SPIKE_CYC            = (SPIKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int IRQ_VALID_NS         = 4000;
    localparam int IRQ_VALID_CYC        = IRQ_VALID_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam int RESET_MIN_PULSE_NS   = 6;

    // bus target states
    typedef enum logic [2:0]
    {
        IEX_IDLE     = 3'b000,
        IEX_ADDR     = 3'b001,
        IEX_ACK_ADDR = 3'b010,
        IEX_WR_BYTE  = 3'b011,
        IEX_ACK_WR   = 3'b100,
        IEX_RD_BYTE  = 3'b101,
        IEX_ACK_RD   = 3'b110
    } iex_state_e;

endpackage

// *** design/iex_port_irq.sv ***
// change detector and pending flag of one eight-pin port
`timescale 1ns/1ps
module iex_port_irq
    import iex_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              srst,
    input  wire logic [PORT_W-1:0] pin,
    input  wire logic [PORT_W-1:0] dir_in,
    input  wire logic              rd_clr,
    output logic                   pend
);

    logic [PORT_W-1:0] orig;
    logic              armed;

    // reference levels, taken again at each read of this port
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            orig  <= '0;
            armed <= 1'b0;
        end
        else if (srst || !armed)
        begin
            orig  <= pin;
            armed <= !srst;
        end
        else if (rd_clr)
        begin
            orig <= pin;            // see RL8
        end
    end

    // pending while any input pin differs from its reference
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pend <= 1'b0;
        else if (srst || !armed)
            pend <= 1'b0;
        else
            pend <= |((pin ^ orig) & dir_in);   // see RL6, see RL7, see RL10, see RL11
    end

endmodule

// *** design/iex_sync.sv ***
// two flip-flop synchroniser with an optional per-bit glitch filter
`timescale 1ns/1ps
module iex_sync
    import iex_pkg::*;
#(
    parameter int         W      = 1,
    parameter int         FILT   = 0,
    parameter logic [W-1:0] INIT = '0
)
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;

    // two-stage synchroniser, first stage read only by the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1 <= INIT;
            s2 <= INIT;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic [2:0] cnt;
            // accept a new level only once it has held for FILT cycles
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    q[i] <= INIT[i];
                    cnt  <= 3'h0;
                end
                else if (FILT == 0 || s2[i] == q[i])
                begin
                    q[i] <= s2[i];
                    cnt  <= 3'h0;
                end
                else if (cnt == 3'(FILT - 1))
                begin
                    q[i] <= s2[i];
                    cnt  <= 3'h0;
                end
                else
                begin
                    cnt <= cnt + 3'h1;
                end
            end
        end
    endgenerate

endmodule

// *** design/iex_top.sv ***
// i2c target, registers, pin drivers and interrupt of the port expander
//
// How it works
// RL1 - reset pin low holds registers and bus
// RL2 - power-on reset initialises everything to defaults
// RL3 - input pins have both drivers off
// RL4 - output pins drive high or low per value
// RL5 - every reset leaves all pins inputs
// RL6 - input pin edge asserts the interrupt
// RL7 - interrupt clears on level return or read
// RL8 - read clear happens at acknowledge clock rise
// RL9 - changes after a clear signal again
// RL10 - other targets and outputs never interrupt
// RL11 - output to input switch may interrupt falsely
// RL12 - clear tracked separately for each port
// RL13 - interrupt pin only pulls low
// RL14 - controller rewrites command after reading
// RL15 - start is data falling with clock high
// RL16 - address byte msb first, general call ignored
// RL17 - matching address is acknowledged low
// RL18 - address selects stay fixed during transfers
// RL19 - data stable while clock high
// RL20 - stop is data rising with clock high
// RL21 - every received byte is acknowledged
// RL22 - nack ends read, data line released
// RL23 - address is fixed bits plus selects
// RL24 - first written byte is the command
// RL25 - input registers show pin levels, inverted where the polarity bit is set
// RL26 - direction one is input, zero output
// RL27 - bus and pins synchronised, bus filtered
// RL28 - interrupt is or of port flags
`timescale 1ns/1ps
module iex_top
    import iex_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        reset_pin_n,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic        addr_sel_lo,
    input  wire logic        addr_sel_hi,
    input  wire logic [15:0] pin_i,
    output logic      [15:0] high_side_driver,
    output logic      [15:0] low_side_driver,
    output logic             int_o,
    output logic             int_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [1:0]  bus_s;
    logic [2:0]  misc_s;
    logic [15:0] pin_s;
    logic        scl_f;
    logic        sda_f;
    logic        bus_rst;

    // bus lines pass a spike filter after the synchroniser
    iex_sync #(.W(2), .FILT(SPIKE_CYC), .INIT(2'h3)) u_bus_sync   // see RL27
    (
        .clk   (core_clk),
        .rst_n (rst_n),
        .d     ({scl_i, sda_i}),
        .q     (bus_s)
    );

    // reset pin and address selects
    iex_sync #(.W(3), .FILT(0), .INIT(3'h0)) u_misc_sync
    (
        .clk   (core_clk),
        .rst_n (rst_n),
        .d     ({reset_pin_n, addr_sel_hi, addr_sel_lo}),
        .q     (misc_s)
    );

    // port pins
    iex_sync #(.W(16), .FILT(0), .INIT(16'h0000)) u_pin_sync      // see RL27
    (
        .clk   (core_clk),
        .rst_n (rst_n),
        .d     (pin_i),
        .q     (pin_s)
    );

    assign scl_f   = bus_s[1];
    assign sda_f   = bus_s[0];
    assign bus_rst = !misc_s[2];    // see RL1

    ////////////////////////////////////////////////////////////////////////////
    // bus condition detection

    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    // previous filtered levels
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    assign scl_rise   = scl_f && !scl_d;
    assign scl_fall   = !scl_f && scl_d;
    assign start_cond = scl_f && scl_d && sda_d && !sda_f;  // see RL15, see RL19
    assign stop_cond  = scl_f && scl_d && !sda_d && sda_f;  // see RL20, see RL19

    ////////////////////////////////////////////////////////////////////////////
    // registers and read data

    logic [15:0] out_q;
    logic [15:0] pol_q;
    logic [15:0] cfg_q;
    logic [2:0]  cmd;
    logic        wr_stb;
    logic [2:0]  wr_sel;
    logic [7:0]  wr_data;
    logic [7:0]  rd_val;

    // value returned for the current command
    always_comb
    begin
        case (cmd)
            CMD_IN0:  rd_val = pin_s[7:0] ^ pol_q[7:0];      // see RL25
            CMD_IN1:  rd_val = pin_s[15:8] ^ pol_q[15:8];    // see RL25
            CMD_OUT0: rd_val = out_q[7:0];
            CMD_OUT1: rd_val = out_q[15:8];
            CMD_POL0: rd_val = pol_q[7:0];
            CMD_POL1: rd_val = pol_q[15:8];
            CMD_CFG0: rd_val = cfg_q[7:0];
            default:  rd_val = cfg_q[15:8];
        endcase
    end

    // register writes, input registers ignore writes
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_q <= OUT_RST;                   // see RL2
            pol_q <= POL_RST;
            cfg_q <= CFG_RST;                   // see RL5
        end
        else if (bus_rst)
        begin
            out_q <= OUT_RST;                   // see RL1
            pol_q <= POL_RST;
            cfg_q <= CFG_RST;                   // see RL5
        end
        else if (wr_stb)
        begin
            case (wr_sel)
                CMD_OUT0: out_q[7:0]  <= wr_data;
                CMD_OUT1: out_q[15:8] <= wr_data;
                CMD_POL0: pol_q[7:0]  <= wr_data;
                CMD_POL1: pol_q[15:8] <= wr_data;
                CMD_CFG0: cfg_q[7:0]  <= wr_data;
                CMD_CFG1: cfg_q[15:8] <= wr_data;
                default:  ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus target state machine

    iex_state_e  state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [7:0]  tx;
    logic [2:0]  tx_cmd;
    logic        rw;
    logic        first;
    logic        nack;
    logic [1:0]  rd_clr;

    // serial framing, command capture and read clear pulses
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state   <= IEX_IDLE;            // see RL2
            bit_cnt <= 4'h0;
            shreg   <= 8'h00;
            tx      <= 8'h00;
            tx_cmd  <= CMD_RST;
            rw      <= 1'b0;
            first   <= 1'b0;
            nack    <= 1'b0;
            cmd     <= CMD_RST;
            sda_oe  <= 1'b0;
            wr_stb  <= 1'b0;
            wr_sel  <= CMD_RST;
            wr_data <= 8'h00;
            rd_clr  <= 2'h0;
        end
        else
        begin
            wr_stb <= 1'b0;
            rd_clr <= 2'h0;
            if (bus_rst)
            begin
                state  <= IEX_IDLE;         // see RL1
                cmd    <= CMD_RST;
                sda_oe <= 1'b0;
            end
            else if (start_cond)
            begin
                state   <= IEX_ADDR;        // see RL15
                bit_cnt <= 4'h0;
                sda_oe  <= 1'b0;
            end
            else if (stop_cond)
            begin
                state  <= IEX_IDLE;         // see RL20
                sda_oe <= 1'b0;
            end
            else if (scl_rise)
            begin
                case (state)
                    IEX_ADDR, IEX_WR_BYTE:
                    begin
                        shreg   <= {shreg[6:0], sda_f};     // see RL16
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    IEX_ACK_RD:
                    begin
                        nack <= sda_f;
                        if (tx_cmd == CMD_IN0)
                            rd_clr <= 2'h1;                 // see RL8, see RL12
                        else if (tx_cmd == CMD_IN1)
                            rd_clr <= 2'h2;                 // see RL8, see RL12
                    end
                    default: ;
                endcase
            end
            else if (scl_fall)
            begin
                case (state)
                    IEX_ADDR:
                    begin
                        if (bit_cnt == BYTE_BITS)
                        begin
                            // only this target's address, general call never matches
                            if (shreg[7:1] == {ADDR_FIXED, misc_s[1], misc_s[0]})   // see RL23
                            begin
                                state  <= IEX_ACK_ADDR;
                                sda_oe <= 1'b1;             // see RL17
                                rw     <= shreg[0];
                            end
                            else
                            begin
                                state <= IEX_IDLE;          // see RL10, see RL16
                            end
                        end
                    end
                    IEX_ACK_ADDR:
                    begin
                        if (rw)
                        begin
                            state   <= IEX_RD_BYTE;
                            tx      <= rd_val;
                            tx_cmd  <= cmd;
                            cmd     <= {cmd[2:1], !cmd[0]};
                            sda_oe  <= !rd_val[7];
                            bit_cnt <= 4'h1;
                        end
                        else
                        begin
                            state   <= IEX_WR_BYTE;
                            sda_oe  <= 1'b0;
                            bit_cnt <= 4'h0;
                            first   <= 1'b1;
                        end
                    end
                    IEX_WR_BYTE:
                    begin
                        if (bit_cnt == BYTE_BITS)
                        begin
                            state  <= IEX_ACK_WR;
                            sda_oe <= 1'b1;                 // see RL21
                            first  <= 1'b0;
                            if (first)
                            begin
                                cmd <= shreg[2:0];          // see RL24
                            end
                            else
                            begin
                                wr_stb  <= 1'b1;
                                wr_sel  <= cmd;
                                wr_data <= shreg;
                                cmd     <= {cmd[2:1], !cmd[0]};
                            end
                        end
                    end
                    IEX_ACK_WR:
                    begin
                        state   <= IEX_WR_BYTE;
                        sda_oe  <= 1'b0;
                        bit_cnt <= 4'h0;
                    end
                    IEX_RD_BYTE:
                    begin
                        if (bit_cnt == BYTE_BITS)
                        begin
                            state  <= IEX_ACK_RD;
                            sda_oe <= 1'b0;                 // see RL22
                        end
                        else
                        begin
                            tx      <= {tx[6:0], 1'b0};
                            sda_oe  <= !tx[6];
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                    IEX_ACK_RD:
                    begin
                        if (nack)
                        begin
                            state  <= IEX_IDLE;             // see RL22
                            sda_oe <= 1'b0;
                        end
                        else
                        begin
                            state   <= IEX_RD_BYTE;         // see RL21
                            tx      <= rd_val;
                            tx_cmd  <= cmd;
                            cmd     <= {cmd[2:1], !cmd[0]};
                            sda_oe  <= !rd_val[7];
                            bit_cnt <= 4'h1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt

    logic [1:0] pend;

    genvar p;
    generate
        for (p = 0; p < 2; p++)
        begin : g_port
            iex_port_irq u_irq
            (
                .clk    (core_clk),
                .rst_n  (rst_n),
                .srst   (bus_rst),
                .pin    (pin_s[p*PORT_W +: PORT_W]),
                .dir_in (cfg_q[p*PORT_W +: PORT_W]),
                .rd_clr (rd_clr[p]),                        // see RL12
                .pend   (pend[p])
            );
        end
    endgenerate

    // open-drain interrupt, only ever pulls low
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_oe <= 1'b0;
            int_o  <= 1'b0;
        end
        else
        begin
            int_oe <= |pend;        // see RL28, see RL9
            int_o  <= 1'b0;         // see RL13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers

    // direction one turns both drivers off, zero drives the output value
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            high_side_driver <= 16'h0000;       // see RL5
            low_side_driver  <= 16'h0000;
            sda_o            <= 1'b0;
        end
        else
        begin
            high_side_driver <= ~cfg_q & out_q;     // see RL3, see RL4, see RL26
            low_side_driver  <= ~cfg_q & ~out_q;    // see RL3, see RL4, see RL26
            sda_o            <= 1'b0;
        end
    end

endmodule

// *** sim/iex_i2c_ctl.sv ***
// bus controller model, open drain on data, clock still between frames
`timescale 1ns/1ps
module iex_i2c_ctl
#(
    parameter int LO_NS = 125,
    parameter int HI_NS = 75
)
(
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    logic got;
    // idle bus: clock high, data released to its pull-up
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one bit: set while clock low, long low lets the target answer settle
    task automatic put_bit(input logic b);
        sda_low = !b;
        #(LO_NS);
        scl = 1'b1;
        #(HI_NS - 5);
        got = sda;
        #5;
        scl = 1'b0;
    endtask
    // start (rise 0) or stop (rise 1): data moves while clock is high
    task automatic cond(input logic rise);
        sda_low = rise;
        #(LO_NS);
        scl = 1'b1;
        #(HI_NS);
        sda_low = !rise;
        #(HI_NS);
        if (!rise)
            scl = 1'b0;
    endtask
    // send a byte msb first, return the target acknowledge
    task automatic send(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        put_bit(1'b1);
        ack = !got;
    endtask
    // receive a byte, acknowledge it or leave data high on the last
    task automatic recv(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(1'b1);
            d[i] = got;
        end
        put_bit(!more);
    endtask
endmodule

// *** sim/iex_props.sv ***
// checker bound to the port expander control top
`timescale 1ns/1ps
module iex_props
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        reset_pin_n,
    input wire logic        scl_i,
    input wire logic        sda_o,
    input wire logic        sda_oe,
    input wire logic [15:0] pin_i,
    input wire logic [15:0] high_side_driver,
    input wire logic [15:0] low_side_driver,
    input wire logic        int_o,
    input wire logic        int_oe
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    wire logic [15:0] drv_on = high_side_driver | low_side_driver;
    logic      [3:0]  scl_age;
    ////////////////////////////////////////
    // cycles since the bus clock last rose, held at 15
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            scl_age <= 4'hF;
        else if ($rose(scl_i))
            scl_age <= 4'h0;
        else if (scl_age != 4'hF)
            scl_age <= scl_age + 4'h1;
    end
    ////////////////////////////////////////
    // quiet pins and no interrupt, then a move on inputs only or outputs only
    sequence s_calm;
        $stable(pin_i) [*5] ##0 (reset_pin_n && !int_oe);
    endsequence
    sequence s_in_move;
        pin_i != $past(pin_i) && ((pin_i ^ $past(pin_i)) & drv_on) == 16'h0000;
    endsequence
    sequence s_out_move;
        pin_i != $past(pin_i) && ((pin_i ^ $past(pin_i)) & ~drv_on) == 16'h0000;
    endsequence
    chk_drv_excl: assert property ((high_side_driver & low_side_driver) == 16'h0000)
        else $error("both drivers on for one pin");
    chk_int_drain: assert property (int_o == 1'b0)
        else $error("interrupt pin driven high");
    chk_sda_drain: assert property (sda_oe |-> sda_o == 1'b0)
        else $error("data line driven high");
    chk_sda_still: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
        else $error("data line moved while bus clock high");
    chk_pin_reset:
        assert property (!reset_pin_n [*6] |-> drv_on == 16'h0000 && !int_oe && !sda_oe)
        else $error("reset pin did not clear drivers");
    chk_in_alarm: assert property (s_calm ##1 s_in_move |-> ##[1:8] int_oe)
        else $error("input pin change not signalled");
    chk_out_quiet: assert property (s_calm ##1 s_out_move |=> !int_oe [*6])
        else $error("output pin change raised interrupt");
    chk_int_cause:
        assert property ($fell(int_oe) |-> scl_age <= 4'hC || $past(pin_i, 2) != $past(pin_i, 8)
            || $past(reset_pin_n, 2) != $past(reset_pin_n, 8))
        else $error("interrupt cleared without cause");
endmodule
bind iex_top iex_props u_props
(
    .core_clk(core_clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .scl_i(scl_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .pin_i(pin_i), .high_side_driver(high_side_driver),
    .low_side_driver(low_side_driver), .int_o(int_o), .int_oe(int_oe)
);

// *** sim/tb.sv ***
// self-checking bench of the port expander control block
`timescale 1ns/1ps
module tb;
    import iex_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        reset_pin_n = 1'b1;
    logic        sel_lo = 1'b0;
    logic        sel_hi = 1'b0;
    logic [15:0] pin_i = 16'h0000;
    wire logic   scl, sda_low, sda, sda_o, sda_oe, int_o, int_oe;
    wire logic [15:0] hi_drv, lo_drv;
    logic [7:0]  rdat;
    logic        ack;
    int          bad_count = 0;
    int          num_checks = 0;
    // data wire with pull-up, low while either party pulls
    assign sda = !(sda_low || sda_oe);
    initial
    begin
        forever #12.5 core_clk = !core_clk;
    end
    iex_i2c_ctl ctl (.sda(sda), .scl(scl), .sda_low(sda_low));
    iex_top dut
    (
        .core_clk(core_clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel_lo(sel_lo),
        .addr_sel_hi(sel_hi), .pin_i(pin_i), .high_side_driver(hi_drv),
        .low_side_driver(lo_drv), .int_o(int_o), .int_oe(int_oe)
    );
    ////////////////////////////////////////
    // compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // start a frame with one address byte
    task automatic addr(input logic [7:0] a);
        ctl.cond(1'b0);
        ctl.send(a, ack);
    endtask
    // write command byte and a register pair
    task automatic wr(input logic [6:0] a, input logic [23:0] b);
        addr({a, 1'b0});
        check("addr ack", 16'(ack), 16'h0001);
        for (int i = 2; i >= 0; i--)
        begin
            ctl.send(b[i*8 +: 8], ack);
            check("byte ack", 16'(ack), 16'h0001);
        end
        ctl.cond(1'b1);
    endtask
    // point at a register, repeated start, read one byte then refuse more
    task automatic rd(input logic [7:0] cmd);
        addr(8'hE8);
        ctl.send(cmd, ack);
        addr(8'hE9);
        check("read ack", 16'(ack), 16'h0001);
        ctl.recv(1'b0, rdat);
        ctl.cond(1'b1);
        @(negedge core_clk);
    endtask
    // bounded wait for the interrupt state
    task automatic wait_int(input logic exp);
        int n;
        n = 0;
        while (int_oe !== exp && n < IRQ_VALID_CYC)
        begin
            @(negedge core_clk);
            n++;
        end
        check("int_oe", 16'(int_oe), 16'(exp));
        if (int_oe !== exp)
            end_sim();
    endtask
    ////////////////////////////////////////
    task automatic t_reset;
        check("drivers", hi_drv | lo_drv, 16'h0000);
        check("int sda", 16'({int_oe, sda_oe}), 16'h0000);
        rd(8'h06);
        check("cfg0", 16'(rdat), 16'(CFG_RST[7:0]));
        $display("test reset done");
    endtask
    task automatic t_write;
        wr(7'h74, {8'h07, 8'hF0, 8'h0F});
        wr(7'h74, {8'h02, 8'h55, 8'hAA});
        repeat (4) @(negedge core_clk);
        check("high drv", hi_drv, 16'hAA55 & ~16'hF00F);
        check("low drv", lo_drv, ~16'hAA55 & ~16'hF00F);
        rd(8'h03);
        check("out1", 16'(rdat), 16'h00AA);
        $display("test write done");
    endtask
    task automatic t_addr;
        addr(8'hEA);
        ctl.cond(1'b1);
        check("other addr ack", 16'(ack), 16'h0000);
        addr(8'h00);
        ctl.cond(1'b1);
        check("general call ack", 16'(ack), 16'h0000);
        @(negedge core_clk);
        sel_lo = 1'b1;
        sel_hi = 1'b1;
        wr(7'h77, {8'h02, 8'h00, 8'hFF});
        @(negedge core_clk);
        sel_lo = 1'b0;
        sel_hi = 1'b0;
        repeat (4) @(negedge core_clk);
        check("high drv", hi_drv, 16'hFF00 & ~16'hF00F);
        check("low drv", lo_drv, ~16'hFF00 & ~16'hF00F);
        $display("test address done");
    endtask
    task automatic t_irq;
        pin_i[4] = 1'b1;
        repeat (IRQ_VALID_CYC) @(negedge core_clk);
        check("output pin int", 16'(int_oe), 16'h0000);
        pin_i[0] = 1'b1;
        wait_int(1'b1);
        pin_i[0] = 1'b0;
        wait_int(1'b0);
        pin_i[13] = 1'b1;
        wait_int(1'b1);
        pin_i[2] = 1'b1;
        repeat (8) @(negedge core_clk);
        rd(8'h01);
        check("in1", 16'(rdat), 16'(pin_i[15:8]));
        check("int kept", 16'(int_oe), 16'h0001);
        rd(8'h00);
        check("in0", 16'(rdat), 16'(pin_i[7:0]));
        check("int cleared", 16'(int_oe), 16'h0000);
        wr(7'h74, {8'h02, 8'h00, 8'hFF});
        @(negedge core_clk);
        pin_i[3] = 1'b1;
        wait_int(1'b1);
        pin_i[3] = 1'b0;
        wait_int(1'b0);
        $display("test interrupt done");
    endtask
    task automatic t_rstpin;
        pin_i[1] = 1'b1;
        wait_int(1'b1);
        reset_pin_n = 1'b0;
        repeat (6) @(negedge core_clk);
        check("drivers", hi_drv | lo_drv, 16'h0000);
        check("int", 16'(int_oe), 16'h0000);
        reset_pin_n = 1'b1;
        repeat (6) @(negedge core_clk);
        rd(8'h07);
        check("cfg1", 16'(rdat), 16'(CFG_RST[15:8]));
        rd(8'h02);
        check("out0", 16'(rdat), 16'(OUT_RST[7:0]));
        $display("test reset pin done");
    endtask
    ////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        t_reset();
        t_write();
        t_addr();
        t_irq();
        t_rstpin();
        end_sim();
    end
    // cut a hang short
    initial
    begin
        #1_000_000;
        check("run time", 16'h0001, 16'h0000);
        end_sim();
    end
endmodule
